// ===== logic/tw_defines.vh
// constants for the two-wire master/slave engine
`ifndef TW_DEFINES_VH
`define TW_DEFINES_VH
`define TW_LOW_PHASE 4'h6
`define TW_HIGH_PHASE 4'h4
`define TW_TPR_RESET 7'h01
`define TW_BIT_COUNT 4'h8
`endif

// ===== logic/tw_sync.v
// two-flop synchroniser for the bus pins
`timescale 1ns/1ns
module tw_sync (
  input wire clk,
  input wire resetn,
  input wire din,
  output reg dout
);
  reg meta;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // tw_sync

// ===== logic/tw_engine.v
// two-wire bus engine: master and slave sharing open-drain pins
// Functional notes
// - bus idle only while both lines sensed high
// - each byte is eight data clocks plus one acknowledge clock
// - bytes shift out most significant bit first, each acknowledged
// - receiver may hold clock low; transmitter waits for release
// - start is data falling with clock high; stop is rising
// - busy set on detected start, cleared on detected stop
// - master sends 7-bit address then direction bit, one means read
// - master ends with stop or repeated start
// - data changes only while clock low, except start and stop
// - master clocks ack; transmitter releases, acknowledger pulls low
// - address not acknowledged: master issues stop to abort
// - master receiver acks all bytes but the last
// - master starts a new transfer only when bus idle
// - master seeing low while driving high loses and retires
// - arbitration continues through address and data bits
// - clock low phase 6 units, high phase 4 units
// - clock period is 2*(tpr+1)*(low+high) system clocks
// - standard and fast speeds chosen by timer period value
// - master and slave run independently and concurrently
// - master raises completion events; slave raises receive and transmit request events
// - master flags error on missing ack or lost arbitration
`timescale 1ns/1ns
`include "tw_defines.vh"
module tw_engine #(
  parameter TPR_WIDTH = 7
) (
  input wire clk,
  input wire resetn,
  input wire serial_data_pin_in,
  output reg serial_data_pin_out,
  output reg serial_data_pin_oe_n,
  input wire serial_clock_pin_in,
  output reg serial_clock_pin_out,
  output reg serial_clock_pin_oe_n,
  input wire [TPR_WIDTH-1:0] master_timer_period_reg,
  input wire m_cmd_valid,
  input wire m_cmd_start,
  input wire m_cmd_stop,
  input wire m_cmd_ack,
  input wire [6:0] m_addr,
  input wire m_dir_read,
  input wire [7:0] m_tx_data,
  output reg [7:0] m_rx_data,
  output reg m_busy,
  output reg m_done,
  output reg m_error,
  output reg m_arb_lost,
  output reg bus_busy,
  input wire [6:0] s_own_addr,
  input wire [7:0] s_tx_data,
  input wire s_rx_ready,
  output reg [7:0] s_rx_data,
  output reg s_rx_event,
  output reg s_tx_request,
  output reg s_first_byte
);
  // ==========================================================
  // pin synchronisation and condition detection
  wire sda;
  wire scl;
  reg sda_d;
  reg scl_d;
  reg m_sda_rel;
  reg m_scl_rel;
  reg s_sda_rel;
  reg s_scl_rel;
  tw_sync u_sda (.clk(clk), .resetn(resetn), .din(serial_data_pin_in),
    .dout(sda));
  tw_sync u_scl (.clk(clk), .resetn(resetn), .din(serial_clock_pin_in),
    .dout(scl));
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;
  wire bus_idle = ~bus_busy & sda & scl;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
      bus_busy <= 1'b0;
      serial_data_pin_out <= 1'b0;
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_oe_n <= 1'b1;
      serial_clock_pin_oe_n <= 1'b1;
    end else begin
      sda_d <= sda;
      scl_d <= scl;
      if (start_det)
        bus_busy <= 1'b1;
      else if (stop_det)
        bus_busy <= 1'b0;
      // open drain: either function pulling low wins
      serial_data_pin_oe_n <= m_sda_rel & s_sda_rel;
      serial_clock_pin_oe_n <= m_scl_rel & s_scl_rel;
    end
  end
  // ==========================================================
  // master clock timebase
  reg [TPR_WIDTH:0] pre;
  reg [3:0] unit;
  reg tick;
  // one unit is 2*(tpr+1) system clocks
  wire [TPR_WIDTH:0] pre_max = {master_timer_period_reg, 1'b1};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre <= {(TPR_WIDTH+1){1'b0}};
      tick <= 1'b0;
    end else begin
      tick <= (pre == pre_max);
      if (pre == pre_max)
        pre <= {(TPR_WIDTH+1){1'b0}};
      else
        pre <= pre + 1'b1;
    end
  end
  // ==========================================================
  // master state machine
  localparam [3:0] M_IDLE = 4'h0;
  localparam [3:0] M_START = 4'h1;
  localparam [3:0] M_LOW = 4'h2;
  localparam [3:0] M_HIGH = 4'h3;
  localparam [3:0] M_WAIT = 4'h4;
  localparam [3:0] M_STOP1 = 4'h5;
  localparam [3:0] M_STOP2 = 4'h6;
  localparam [3:0] M_HOLD = 4'h7;
  localparam [3:0] M_RSTART = 4'h8;
  localparam [3:0] M_RETIRE = 4'h9;
  reg [3:0] m_state;
  reg [3:0] m_bit;
  reg [7:0] m_shift;
  reg m_rd;
  reg m_addr_ph;
  reg m_stop_q;
  reg m_ack_q;
  reg m_drive_bit;
  wire ack_slot = (m_bit == `TW_BIT_COUNT);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_state <= M_IDLE;
      m_bit <= 4'h0;
      m_shift <= 8'h00;
      m_rd <= 1'b0;
      m_addr_ph <= 1'b0;
      m_stop_q <= 1'b0;
      m_ack_q <= 1'b0;
      m_drive_bit <= 1'b1;
      m_sda_rel <= 1'b1;
      m_scl_rel <= 1'b1;
      unit <= 4'h0;
      m_rx_data <= 8'h00;
      m_busy <= 1'b0;
      m_done <= 1'b0;
      m_error <= 1'b0;
      m_arb_lost <= 1'b0;
    end else begin
      m_done <= 1'b0;
      if (tick)
        unit <= unit + 1'b1;
      case (m_state)
        M_IDLE: begin
          m_sda_rel <= 1'b1;
          m_scl_rel <= 1'b1;
          if (m_cmd_valid && m_cmd_start && bus_idle) begin
            m_shift <= {m_addr, m_dir_read};
            m_rd <= m_dir_read;
            m_addr_ph <= 1'b1;
            m_stop_q <= m_cmd_stop;
            m_ack_q <= m_cmd_ack;
            m_busy <= 1'b1;
            m_error <= 1'b0;
            m_arb_lost <= 1'b0;
            m_sda_rel <= 1'b0;
            unit <= 4'h0;
            m_state <= M_START;
          end
        end
        M_START: begin
          if (tick && unit == `TW_HIGH_PHASE - 1'b1) begin
            m_scl_rel <= 1'b0;
            m_bit <= 4'h0;
            unit <= 4'h0;
            m_state <= M_LOW;
          end
        end
        M_LOW: begin
          // data set up early in the low phase
          if (tick && unit == 4'h1) begin
            if (ack_slot)
              m_drive_bit <= m_rd && !m_addr_ph ? ~m_ack_q : 1'b1;
            else
              m_drive_bit <= m_rd && !m_addr_ph ? 1'b1 : m_shift[7];
          end
          m_sda_rel <= m_drive_bit;
          if (tick && unit == `TW_LOW_PHASE - 1'b1) begin
            m_scl_rel <= 1'b1;
            unit <= 4'h0;
            m_state <= M_WAIT;
          end
        end
        M_WAIT: begin
          unit <= 4'h0;
          if (scl)
            m_state <= M_HIGH;
        end
        M_HIGH: begin
          // a released bit while receiving is not an arbitration bit
          if (scl_rise || unit == 4'h0 && !tick) begin
            if (m_drive_bit && !sda && !ack_slot &&
                !(m_rd && !m_addr_ph)) begin
              m_sda_rel <= 1'b1;
              m_arb_lost <= 1'b1;
              m_error <= 1'b1;
              m_state <= M_RETIRE;
            end
          end
          if (m_state == M_HIGH && tick &&
              unit == `TW_HIGH_PHASE - 1'b1) begin
            m_scl_rel <= 1'b0;
            unit <= 4'h0;
            if (!ack_slot) begin
              m_shift <= {m_shift[6:0], sda};
              m_bit <= m_bit + 1'b1;
              m_state <= M_LOW;
            end else begin
              m_bit <= 4'h0;
              if (m_rd && !m_addr_ph)
                m_rx_data <= m_shift;
              if (sda && (m_addr_ph || !m_rd)) begin
                m_error <= 1'b1;
                m_drive_bit <= 1'b0;
                m_state <= M_STOP1;
              end else if (!m_addr_ph && (m_stop_q || m_rd && !m_ack_q))
                m_state <= M_STOP1;
              else begin
                m_done <= 1'b1;
                m_addr_ph <= 1'b0;
                m_state <= M_HOLD;
              end
            end
          end
        end
        M_HOLD: begin
          // clock held low between bytes until next command or a stop queued with the address
          m_sda_rel <= 1'b1;
          if (m_cmd_valid) begin
            m_stop_q <= m_cmd_stop;
            m_ack_q <= m_cmd_ack;
            unit <= 4'h0;
            if (m_cmd_start) begin
              m_shift <= {m_addr, m_dir_read};
              m_rd <= m_dir_read;
              m_addr_ph <= 1'b1;
              m_state <= M_RSTART;
            end else begin
              m_shift <= m_tx_data;
              m_state <= M_LOW;
            end
          end else if (m_stop_q && !m_addr_ph) begin
            m_drive_bit <= 1'b0;
            unit <= 4'h0;
            m_state <= M_STOP1;
          end
        end
        M_RSTART: begin
          // full low phase first, so the clock never runs short
          m_sda_rel <= 1'b1;
          if (tick && unit == `TW_LOW_PHASE - 1'b1)
            m_scl_rel <= 1'b1;
          if (m_scl_rel && scl && tick) begin
            m_sda_rel <= 1'b0;
            unit <= 4'h0;
            m_state <= M_START;
          end
        end
        M_STOP1: begin
          m_sda_rel <= 1'b0;
          if (tick && unit == `TW_LOW_PHASE - 1'b1)
            m_scl_rel <= 1'b1;
          if (m_scl_rel && scl && tick) begin
            unit <= 4'h0;
            m_state <= M_STOP2;
          end
        end
        M_STOP2: begin
          if (tick && unit == 4'h1)
            m_sda_rel <= 1'b1;
          if (stop_det) begin
            m_done <= 1'b1;
            m_busy <= 1'b0;
            m_state <= M_IDLE;
          end
        end
        M_RETIRE: begin
          m_sda_rel <= 1'b1;
          m_scl_rel <= 1'b1;
          if (bus_idle) begin
            m_done <= 1'b1;
            m_busy <= 1'b0;
            m_state <= M_IDLE;
          end
        end
        default: m_state <= M_IDLE;
      endcase
    end
  end
  // ==========================================================
  // slave state machine
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ADDR = 3'h1;
  localparam [2:0] S_RX = 3'h2;
  localparam [2:0] S_TX = 3'h3;
  localparam [2:0] S_ACK = 3'h4;
  reg [2:0] s_state;
  reg [3:0] s_bit;
  reg [7:0] s_shift;
  reg s_tx;
  reg s_acked;
  reg s_first;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_state <= S_IDLE;
      s_bit <= 4'h0;
      s_shift <= 8'h00;
      s_tx <= 1'b0;
      s_acked <= 1'b0;
      s_first <= 1'b0;
      s_sda_rel <= 1'b1;
      s_scl_rel <= 1'b1;
      s_rx_data <= 8'h00;
      s_rx_event <= 1'b0;
      s_tx_request <= 1'b0;
      s_first_byte <= 1'b0;
    end else begin
      s_rx_event <= 1'b0;
      s_tx_request <= 1'b0;
      if (start_det) begin
        s_state <= S_ADDR;
        s_bit <= 4'h0;
        s_sda_rel <= 1'b1;
      end else if (stop_det) begin
        s_state <= S_IDLE;
        s_sda_rel <= 1'b1;
        s_scl_rel <= 1'b1;
      end else begin
        case (s_state)
          S_IDLE: s_sda_rel <= 1'b1;
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              s_shift <= {s_shift[6:0], sda};
              s_bit <= s_bit + 1'b1;
            end
            if (scl_fall && s_bit == `TW_BIT_COUNT) begin
              s_bit <= 4'h0;
              if (s_state == S_ADDR) begin
                if (s_shift[7:1] == s_own_addr) begin
                  s_sda_rel <= 1'b0;
                  s_tx <= s_shift[0];
                  s_first <= 1'b1;
                  s_state <= S_ACK;
                end else
                  s_state <= S_IDLE;
              end else begin
                s_rx_data <= s_shift;
                s_rx_event <= 1'b1;
                s_first_byte <= s_first;
                s_first <= 1'b0;
                s_scl_rel <= s_rx_ready;
                s_sda_rel <= ~s_rx_ready;
                s_state <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (!s_scl_rel && s_rx_ready) begin
              s_scl_rel <= 1'b1;
              s_sda_rel <= 1'b0;
            end
            if (scl_rise)
              s_acked <= ~sda;
            if (scl_fall && s_scl_rel) begin
              s_sda_rel <= 1'b1;
              if (s_tx) begin
                s_shift <= s_tx_data;
                s_tx_request <= 1'b1;
                s_sda_rel <= s_tx_data[7];
                s_state <= S_TX;
              end else
                s_state <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (s_bit == 4'h7) begin
                s_sda_rel <= 1'b1;
                s_bit <= s_bit + 1'b1;
              end else if (s_bit == `TW_BIT_COUNT) begin
                s_bit <= 4'h0;
                s_state <= S_IDLE;
              end else begin
                s_sda_rel <= s_shift[6];
                s_shift <= {s_shift[6:0], 1'b1};
                s_bit <= s_bit + 1'b1;
              end
            end
            if (scl_rise && s_bit == `TW_BIT_COUNT && !sda) begin
              s_acked <= 1'b1;
              s_state <= S_ACK;
            end
          end
          default: s_state <= S_IDLE;
        endcase
      end
    end
  end
endmodule // tw_engine

// ===== verification/twe_props.sv
// assertion checker for the two-wire bus engine pins and status
`timescale 1ns/1ns
module twe_props #(
  parameter TPR_WIDTH = 7
) (
  input wire clk,
  input wire resetn,
  input wire serial_data_pin_in,
  input wire serial_clock_pin_in,
  input wire serial_data_pin_oe_n,
  input wire serial_clock_pin_oe_n,
  input wire m_done,
  input wire m_error,
  input wire m_arb_lost,
  input wire bus_busy
);
  // ============================================================
  // bus conditions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_start;
    $fell(serial_data_pin_in) && serial_clock_pin_in &&
      $past(serial_clock_pin_in);
  endsequence
  sequence s_stop;
    $rose(serial_data_pin_in) && serial_clock_pin_in &&
      $past(serial_clock_pin_in);
  endsequence
  // ============================================================
  // properties; sync latency allows a few cycles of slack
  a_start_busy: assert property (s_start |-> ##[1:6] bus_busy)
    else $error("bus not busy after start");
  a_stop_free: assert property (s_stop |-> ##[1:6] !bus_busy)
    else $error("bus not free after stop");
  a_idle_clock: assert property (!bus_busy |-> serial_clock_pin_oe_n)
    else $error("clock pulled while bus idle");
  a_release_stop: assert property ($rose(serial_data_pin_oe_n) &&
    serial_clock_pin_in && $past(serial_clock_pin_in) |-> ##[1:6] !bus_busy)
    else $error("data released under high clock without stop");
  a_scl_high_min: assert property ($rose(serial_clock_pin_oe_n) |->
    serial_clock_pin_oe_n [*8])
    else $error("clock high phase too short");
  a_scl_low_min: assert property ($fell(serial_clock_pin_oe_n) |->
    !serial_clock_pin_oe_n [*8])
    else $error("clock low phase too short");
  a_arb_error: assert property ($rose(m_arb_lost) |-> ##[0:2] m_error)
    else $error("lost arbitration without error");
  a_arb_retire: assert property ($rose(m_arb_lost) |->
    serial_data_pin_oe_n [*4])
    else $error("data still driven after lost arbitration");
  a_done_pulse: assert property (m_done |=> !m_done)
    else $error("done longer than one cycle");
endmodule // twe_props

bind tw_engine twe_props #(.TPR_WIDTH(TPR_WIDTH)) i_props (
  .clk(clk), .resetn(resetn), .serial_data_pin_in(serial_data_pin_in),
  .serial_clock_pin_in(serial_clock_pin_in),
  .serial_data_pin_oe_n(serial_data_pin_oe_n),
  .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .m_done(m_done),
  .m_error(m_error), .m_arb_lost(m_arb_lost), .bus_busy(bus_busy));

// ===== verification/twe_slave_model.sv
// slave device model on the far side of the open-drain bus
`timescale 1ns/1ns
module twe_slave_model #(
  parameter [6:0] OWN_ADDR = 7'h3B
) (
  input wire sda,
  input wire scl,
  input wire [7:0] tx_byte,
  input wire [15:0] stretch_ns,
  output reg sda_pull,
  output reg scl_pull
);
  reg [7:0] b;
  reg acked;
  reg rd;
  reg [7:0] got [$];
  integer i;
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
  end
  // ============================================================
  // bit tasks: data moves 20 ns after a clock fall, never while high
  task get_byte;
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    got.push_back(b);
  endtask
  task give_ack;
    @(negedge scl);
    #20 sda_pull = 1'b1;
    @(negedge scl);
    #20 sda_pull = 1'b0;
    // stretching only on writes: a read bit must be set up first
    if (stretch_ns != 16'h0000 && !rd) begin
      scl_pull = 1'b1;
      #(stretch_ns) scl_pull = 1'b0;
    end
  endtask
  task send_byte;
    for (i = 7; i >= 0; i = i - 1) begin
      sda_pull = ~tx_byte[i];
      @(negedge scl);
      #20;
    end
    sda_pull = 1'b0;
    @(posedge scl) acked = ~sda;
  endtask
  // ============================================================
  // frame handling
  initial forever begin : frame
    @(negedge sda);
    if (scl === 1'b1) begin
      get_byte;
      rd = b[0];
      if (b[7:1] == OWN_ADDR) begin
        give_ack;
        if (rd) begin
          acked = 1'b1;
          while (acked) begin
            send_byte;
            @(negedge scl);
            #20;
          end
        end else
          forever begin
            get_byte;
            give_ack;
          end
      end
    end
  end
  always @(posedge sda)
    if (scl === 1'b1) begin
      disable frame;
      sda_pull = 1'b0;
      scl_pull = 1'b0;
    end
endmodule // twe_slave_model

// ===== verification/two_wire_master_slave_engine_tb_top.sv
// self-checking bench: engine as master against a slave model
`timescale 1ns/1ns
module two_wire_master_slave_engine_tb_top;
  localparam [6:0] PEER = 7'h3B;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg m_cmd_valid, m_cmd_start, m_cmd_stop, m_cmd_ack, m_dir_read;
  reg s_rx_ready;
  reg [6:0] m_addr, s_own_addr, master_timer_period_reg;
  reg [7:0] m_tx_data, s_tx_data, peer_tx;
  reg [15:0] stretch_ns;
  reg [31:0] seed = 32'hC472E23F;
  reg [31:0] r, d;
  reg [7:0] expq [$];
  wire [7:0] m_rx_data, s_rx_data;
  wire m_busy, m_done, m_error, m_arb_lost, bus_busy;
  wire s_rx_event, s_tx_request, s_first_byte;
  wire sda_out, sda_oe_n, scl_out, scl_oe_n, peer_sda, peer_scl;
  wire sda = (sda_oe_n | sda_out) & ~peer_sda;
  wire scl = (scl_oe_n | scl_out) & ~peer_scl;
  integer mismatches = 0;
  integer n_compared = 0;
  integer k, j, n, w;
  always #4 clk = ~clk;
  tw_engine #(.TPR_WIDTH(7)) i_dut (.clk(clk), .resetn(resetn),
    .serial_data_pin_in(sda), .serial_data_pin_out(sda_out),
    .serial_data_pin_oe_n(sda_oe_n), .serial_clock_pin_in(scl),
    .serial_clock_pin_out(scl_out), .serial_clock_pin_oe_n(scl_oe_n),
    .master_timer_period_reg(master_timer_period_reg),
    .m_cmd_valid(m_cmd_valid), .m_cmd_start(m_cmd_start),
    .m_cmd_stop(m_cmd_stop), .m_cmd_ack(m_cmd_ack), .m_addr(m_addr),
    .m_dir_read(m_dir_read), .m_tx_data(m_tx_data), .m_rx_data(m_rx_data),
    .m_busy(m_busy), .m_done(m_done), .m_error(m_error),
    .m_arb_lost(m_arb_lost), .bus_busy(bus_busy), .s_own_addr(s_own_addr),
    .s_tx_data(s_tx_data), .s_rx_ready(s_rx_ready), .s_rx_data(s_rx_data),
    .s_rx_event(s_rx_event), .s_tx_request(s_tx_request),
    .s_first_byte(s_first_byte));
  twe_slave_model #(.OWN_ADDR(PEER)) i_peer (.sda(sda), .scl(scl),
    .tx_byte(peer_tx), .stretch_ns(stretch_ns), .sda_pull(peer_sda),
    .scl_pull(peer_scl));
  // ============================================================
  // helpers
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input string what, input [7:0] exp, input [7:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one command pulse, then a bounded wait for the done pulse
  task cmd(input st, input sp, input ak, input rd, input [6:0] ad,
      input [7:0] dt);
    @(negedge clk);
    {m_cmd_start, m_cmd_stop, m_cmd_ack, m_dir_read} = {st, sp, ak, rd};
    m_addr = ad;
    m_tx_data = dt;
    m_cmd_valid = 1'b1;
    @(negedge clk);
    m_cmd_valid = 1'b0;
    w = 0;
    while (m_done !== 1'b1 && w < 20000) begin
      @(negedge clk);
      w = w + 1;
    end
    if (w >= 20000) check("done wait", 8'h01, 8'h00);
    @(negedge clk);
  endtask
  task conclude;
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches = mismatches + 1;
    conclude;
  end
  // ============================================================
  // scenarios
  initial begin
    {m_cmd_valid, m_cmd_start, m_cmd_stop, m_cmd_ack, m_dir_read} = 5'h00;
    {m_addr, m_tx_data, s_tx_data, peer_tx} = 31'h0;
    s_own_addr = 7'h40;
    s_rx_ready = 1'b1;
    stretch_ns = 16'h0000;
    master_timer_period_reg = 7'h00;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    // address nobody answers: stop and error
    cmd(1'b1, 1'b0, 1'b0, 1'b0, PEER ^ 7'h01, 8'h00);
    check("nack error", 8'h01, {7'h0, m_error});
    check("nack free", 8'h00, {7'h0, bus_busy});
    for (k = 0; k < 4; k = k + 1) begin
      r = rnd();
      master_timer_period_reg = {6'h00, r[0]};
      stretch_ns = r[1] ? 16'h0190 : 16'h0000;
      s_own_addr = {1'b1, r[7:2]};
      s_tx_data = r[15:8];
      peer_tx = r[31:24];
      n = 1 + r[17:16];
      expq.delete();
      i_peer.got.delete();
      expq.push_back({PEER, 1'b0});
      cmd(1'b1, 1'b0, 1'b0, 1'b0, PEER, 8'h00);
      check("write addr err", 8'h00, {7'h0, m_error});
      for (j = 1; j <= n; j = j + 1) begin
        d = rnd();
        expq.push_back(d[7:0]);
        cmd(1'b0, j == n, 1'b0, 1'b0, PEER, d[7:0]);
      end
      check("write err", 8'h00, {7'h0, m_error});
      check("write free", 8'h00, {7'h0, bus_busy});
      check("byte count", 8'(expq.size()), 8'(i_peer.got.size()));
      for (j = 0; j < expq.size(); j = j + 1)
        check("peer byte", expq[j], i_peer.got[j]);
      i_peer.got.delete();
      cmd(1'b1, 1'b0, 1'b0, 1'b1, PEER, 8'h00);
      check("read addr", {PEER, 1'b1}, i_peer.got[0]);
      cmd(1'b0, 1'b1, 1'b0, 1'b1, PEER, 8'h00);
      check("read data", peer_tx, m_rx_data);
      check("read err", 8'h00, {7'h0, m_error});
    end
    conclude;
  end
endmodule // two_wire_master_slave_engine_tb_top
